/* File: atm_pkg.sv */
package atm_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0]  IDX_TRIM_SRC_CTRL   = 8'h21;
  localparam logic [7:0]  IDX_CAL_PHASE_TGT   = 8'h22;
  localparam logic [7:0]  IDX_CAL_RESULT_DISP = 8'h23;
  localparam logic [7:0]  IDX_MOD_DEPTH_CTRL  = 8'h24;
  localparam logic [7:0]  IDX_SEGMENT_MASK    = 8'h26;
  localparam logic [7:0]  IDX_CAL_CONTROL     = 8'h30;
  localparam int          ADDR_W              = 12;
  localparam logic [11:0] ADDR_TRIM_SRC_CTRL   = {2'h0, IDX_TRIM_SRC_CTRL, 2'h0};
  localparam logic [11:0] ADDR_CAL_PHASE_TGT   = {2'h0, IDX_CAL_PHASE_TGT, 2'h0};
  localparam logic [11:0] ADDR_CAL_RESULT_DISP = {2'h0, IDX_CAL_RESULT_DISP, 2'h0};
  localparam logic [11:0] ADDR_MOD_DEPTH_CTRL  = {2'h0, IDX_MOD_DEPTH_CTRL, 2'h0};
  localparam logic [11:0] ADDR_SEGMENT_MASK    = {2'h0, IDX_SEGMENT_MASK, 2'h0};
  localparam logic [11:0] ADDR_CAL_CONTROL     = {2'h0, IDX_CAL_CONTROL, 2'h0};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TRIM_SRC_BIT  = 7;
  localparam int TRIM_MAN_MSB  = 6;
  localparam int TRIM_MAN_LSB  = 3;
  localparam int DISP_RES_MSB  = 7;
  localparam int DISP_RES_LSB  = 4;
  localparam int DISP_ERR_BIT  = 3;
  localparam int MOD_SRC_BIT   = 7;
  localparam int MOD_LVL_MSB   = 6;
  localparam int MOD_LVL_LSB   = 1;
  localparam int CTL_DEFAULT_BIT = 0;

  // ----------------------------------------
  // Reset values and write masks
  // ----------------------------------------
  localparam logic [7:0] RST_TRIM_SRC_CTRL = 8'h00;
  localparam logic [7:0] RST_CAL_PHASE_TGT = 8'h80;
  localparam logic [7:0] RST_CAL_RESULT    = 8'h00;
  localparam logic [7:0] RST_MOD_DEPTH     = 8'h00;
  localparam logic [7:0] RST_SEGMENT_MASK  = 8'h00;
  localparam logic [7:0] MSK_TRIM_SRC_CTRL = 8'hf8;
  localparam logic [7:0] MSK_CAL_PHASE_TGT = 8'hff;
  localparam logic [7:0] MSK_MOD_DEPTH     = 8'hfe;
  localparam logic [7:0] MSK_SEGMENT_MASK  = 8'hff;

  // ----------------------------------------
  // AXI responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : atm_pkg

/* File: atm_reg_if.sv */
`timescale 1ns/1ps
interface atm_reg_if;
  logic                   wr_en;
  logic [atm_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0]             wr_data;
  logic [3:0]             wr_strb;
  logic                   wr_ok;
  logic [atm_pkg::ADDR_W-1:0] rd_addr;
  logic [7:0]             rd_data;
  logic                   rd_ok;

  modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr,
               input wr_ok, input rd_data, input rd_ok);
  modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr,
                output wr_ok, output rd_data, output rd_ok);
endinterface : atm_reg_if

/* File: atm_axil_slave.sv */
`timescale 1ns/1ps
module atm_axil_slave (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Write address and data
  input  wire logic                       awvalid,
  output      logic                       awready,
  input  wire logic [atm_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       wvalid,
  output      logic                       wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  // Write response
  output      logic                       bvalid,
  input  wire logic                       bready,
  output      logic [1:0]                 bresp,
  // Read channels
  input  wire logic                       arvalid,
  output      logic                       arready,
  input  wire logic [atm_pkg::ADDR_W-1:0] araddr,
  output      logic                       rvalid,
  input  wire logic                       rready,
  output      logic [31:0]                rdata,
  output      logic [1:0]                 rresp,
  // Register side
  atm_reg_if.bus                          rif
);

  logic                       aw_held_ff;
  logic                       w_held_ff;
  logic [atm_pkg::ADDR_W-1:0] aw_addr_ff;
  logic [7:0]                 w_data_ff;
  logic [3:0]                 w_strb_ff;
  logic                       bvalid_ff;
  logic [1:0]                 bresp_ff;
  logic                       rvalid_ff;
  logic [31:0]                rdata_ff;
  logic [1:0]                 rresp_ff;
  logic                       do_write;
  logic                       awready_ff;
  logic                       wready_ff;
  logic                       arready_ff;
  logic                       nxt_aw_held;
  logic                       nxt_w_held;
  logic                       nxt_bvalid;
  logic                       nxt_rvalid;

  assign awready  = awready_ff;
  assign wready   = wready_ff;
  assign arready  = arready_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

  // ----------------------------------------
  // Registered ready flags
  // ----------------------------------------
  assign nxt_aw_held = (aw_held_ff || (awvalid && awready_ff)) && !do_write;
  assign nxt_w_held  = (w_held_ff || (wvalid && wready_ff)) && !do_write;
  assign nxt_bvalid  = do_write || (bvalid_ff && !bready);
  assign nxt_rvalid  = (arvalid && arready_ff) || (rvalid_ff && !rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      arready_ff <= 1'b0;
    end else begin
      awready_ff <= !nxt_aw_held && !nxt_bvalid;
      wready_ff  <= !nxt_w_held && !nxt_bvalid;
      arready_ff <= !nxt_rvalid;
    end
  end

  assign rif.wr_en   = do_write;
  assign rif.wr_addr = aw_addr_ff;
  assign rif.wr_data = w_data_ff;
  assign rif.wr_strb = w_strb_ff;
  assign rif.rd_addr = araddr;

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata  = rdata_ff;
  assign rresp  = rresp_ff;

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= 8'h00;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= atm_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= wdata[7:0];
        w_strb_ff <= wstrb;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= rif.wr_ok ? atm_pkg::RESP_OKAY : atm_pkg::RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= atm_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rif.rd_data};
      rresp_ff  <= rif.rd_ok ? atm_pkg::RESP_OKAY : atm_pkg::RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule : atm_axil_slave

/* File: atm_regs.sv */
`timescale 1ns/1ps
// Functional notes
// - Bit 7 of trim source control picks the trim switch source.
// - Source bit 0 drives trim switches from antenna calibration result.
// - Source bit 1 drives trim switches from manual bits 6..3, bit 6 MSB.
// - Manual trim bit 1 turns on switch in both trim pin groups.
// - Eight-bit target phase, default MSB 1, others 0.
// - Calibration outcome stored read-only in display bits 7..4, bit 7 MSB.
// - Displayed result bit 1 means that trim transistor on, result selected.
// - Error flag bit 3 set when calibration cannot reach resonance.
// - Display register cleared at power-up and on set-default.
// - Writable registers return to defaults at power-up and set-default.
// - Modulation source 0 takes level from six-bit field bits 6..1.
// - Modulation depth calibration updates six-bit level when selected.
// - Modulation source 1 takes level from eight-bit segment mask.
// - Manual mask bit 1 disables matching segment only while AM modulated.
module atm_regs #(
  parameter int TRIM_W = 4,
  parameter int LVL_W  = 6,
  parameter int SEG_W  = 8
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address and data
  input  wire logic                       s_axi_awvalid,
  output      logic                       s_axi_awready,
  input  wire logic [atm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output      logic                       s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  // AXI4-Lite write response
  output      logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output      logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                       s_axi_arvalid,
  output      logic                       s_axi_arready,
  input  wire logic [atm_pkg::ADDR_W-1:0] s_axi_araddr,
  output      logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output      logic [31:0]                s_axi_rdata,
  output      logic [1:0]                 s_axi_rresp,
  // Antenna calibration engine
  input  wire logic                       ant_cal_done,
  input  wire logic [TRIM_W-1:0]          ant_cal_result,
  input  wire logic                       ant_cal_fail,
  // Modulation depth calibration engine
  input  wire logic                       mod_cal_done,
  input  wire logic [LVL_W-1:0]           mod_cal_level,
  // Driver state
  input  wire logic                       am_modulated,
  // Trim switch and driver outputs
  output      logic [TRIM_W-1:0]          trim_pins_group_one,
  output      logic [TRIM_W-1:0]          trim_pins_group_two,
  output      logic [7:0]                 target_phase,
  output      logic                       mod_level_use_field,
  output      logic [LVL_W-1:0]           mod_level,
  output      logic [SEG_W-1:0]           segment_disable
);

  atm_reg_if rif ();

  logic [7:0]        trim_ctrl_ff;
  logic [7:0]        phase_tgt_ff;
  logic [7:0]        cal_disp_ff;
  logic [7:0]        mod_ctrl_ff;
  logic [7:0]        seg_mask_ff;
  logic [TRIM_W-1:0] trim_one_ff;
  logic [TRIM_W-1:0] trim_two_ff;
  logic [7:0]        tphase_ff;
  logic              use_field_ff;
  logic [LVL_W-1:0]  mod_level_ff;
  logic [SEG_W-1:0]  seg_dis_ff;
  logic              set_default;
  logic              wr_byte;
  logic [7:0]        rd_val;
  logic              rd_hit;
  logic              wr_hit;
  logic [TRIM_W-1:0] nxt_trim;
  logic              modulation_source_select;
  logic [LVL_W-1:0]  lvl_field;

  atm_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .awaddr  (s_axi_awaddr),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .bresp   (s_axi_bresp),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .araddr  (s_axi_araddr),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rif     (rif)
  );

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign wr_byte = rif.wr_en && rif.wr_strb[0];
  assign set_default = wr_byte && (rif.wr_addr == atm_pkg::ADDR_CAL_CONTROL) &&
                       rif.wr_data[atm_pkg::CTL_DEFAULT_BIT];

  always_comb begin
    wr_hit = 1'b1;
    if (rif.wr_addr == atm_pkg::ADDR_TRIM_SRC_CTRL) begin
      wr_hit = 1'b1;
    end else if (rif.wr_addr == atm_pkg::ADDR_CAL_PHASE_TGT) begin
      wr_hit = 1'b1;
    end else if (rif.wr_addr == atm_pkg::ADDR_CAL_RESULT_DISP) begin
      wr_hit = 1'b1;
    end else if (rif.wr_addr == atm_pkg::ADDR_MOD_DEPTH_CTRL) begin
      wr_hit = 1'b1;
    end else if (rif.wr_addr == atm_pkg::ADDR_SEGMENT_MASK) begin
      wr_hit = 1'b1;
    end else if (rif.wr_addr == atm_pkg::ADDR_CAL_CONTROL) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end
  assign rif.wr_ok = wr_hit;

  // ----------------------------------------
  // Trim source control
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || set_default) begin
      trim_ctrl_ff <= atm_pkg::RST_TRIM_SRC_CTRL;
    end else if (wr_byte && rif.wr_addr == atm_pkg::ADDR_TRIM_SRC_CTRL) begin
      trim_ctrl_ff <= rif.wr_data & atm_pkg::MSK_TRIM_SRC_CTRL;
    end
  end

  // ----------------------------------------
  // Calibration phase target
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || set_default) begin
      phase_tgt_ff <= atm_pkg::RST_CAL_PHASE_TGT;
    end else if (wr_byte && rif.wr_addr == atm_pkg::ADDR_CAL_PHASE_TGT) begin
      phase_tgt_ff <= rif.wr_data & atm_pkg::MSK_CAL_PHASE_TGT;
    end
  end

  // ----------------------------------------
  // Calibration result display
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || set_default) begin
      cal_disp_ff <= atm_pkg::RST_CAL_RESULT;
    end else if (ant_cal_done) begin
      cal_disp_ff <= 8'h00;
      cal_disp_ff[atm_pkg::DISP_RES_MSB:atm_pkg::DISP_RES_LSB] <= ant_cal_result;
      cal_disp_ff[atm_pkg::DISP_ERR_BIT] <= ant_cal_fail;
    end
  end

  // ----------------------------------------
  // Modulation depth control
  // ----------------------------------------
  assign modulation_source_select = mod_ctrl_ff[atm_pkg::MOD_SRC_BIT];
  assign lvl_field = mod_ctrl_ff[atm_pkg::MOD_LVL_MSB:atm_pkg::MOD_LVL_LSB];

  always_ff @(posedge aclk) begin
    if (!aresetn || set_default) begin
      mod_ctrl_ff <= atm_pkg::RST_MOD_DEPTH;
    end else if (mod_cal_done && !modulation_source_select) begin
      mod_ctrl_ff[atm_pkg::MOD_LVL_MSB:atm_pkg::MOD_LVL_LSB] <= mod_cal_level;
    end else if (wr_byte && rif.wr_addr == atm_pkg::ADDR_MOD_DEPTH_CTRL) begin
      mod_ctrl_ff <= rif.wr_data & atm_pkg::MSK_MOD_DEPTH;
    end
  end

  // ----------------------------------------
  // Manual segment mask
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || set_default) begin
      seg_mask_ff <= atm_pkg::RST_SEGMENT_MASK;
    end else if (wr_byte && rif.wr_addr == atm_pkg::ADDR_SEGMENT_MASK) begin
      seg_mask_ff <= rif.wr_data & atm_pkg::MSK_SEGMENT_MASK;
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (rif.rd_addr == atm_pkg::ADDR_TRIM_SRC_CTRL) begin
      rd_val = trim_ctrl_ff;
    end else if (rif.rd_addr == atm_pkg::ADDR_CAL_PHASE_TGT) begin
      rd_val = phase_tgt_ff;
    end else if (rif.rd_addr == atm_pkg::ADDR_CAL_RESULT_DISP) begin
      rd_val = cal_disp_ff;
    end else if (rif.rd_addr == atm_pkg::ADDR_MOD_DEPTH_CTRL) begin
      rd_val = mod_ctrl_ff;
    end else if (rif.rd_addr == atm_pkg::ADDR_SEGMENT_MASK) begin
      rd_val = seg_mask_ff;
    end else if (rif.rd_addr == atm_pkg::ADDR_CAL_CONTROL) begin
      rd_val = 8'h00;
    end else begin
      rd_hit = 1'b0;
    end
  end
  assign rif.rd_data = rd_val;
  assign rif.rd_ok   = rd_hit;

  // ----------------------------------------
  // Trim switch drive
  // ----------------------------------------
  always_comb begin
    if (trim_ctrl_ff[atm_pkg::TRIM_SRC_BIT]) begin
      nxt_trim = trim_ctrl_ff[atm_pkg::TRIM_MAN_MSB:atm_pkg::TRIM_MAN_LSB];
    end else begin
      nxt_trim = cal_disp_ff[atm_pkg::DISP_RES_MSB:atm_pkg::DISP_RES_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_one_ff <= '0;
      trim_two_ff <= '0;
    end else begin
      trim_one_ff <= nxt_trim;
      trim_two_ff <= nxt_trim;
    end
  end

  // ----------------------------------------
  // Driver level drive
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tphase_ff    <= atm_pkg::RST_CAL_PHASE_TGT;
      use_field_ff <= 1'b1;
      mod_level_ff <= '0;
      seg_dis_ff   <= '0;
    end else begin
      tphase_ff    <= phase_tgt_ff;
      use_field_ff <= !modulation_source_select;
      mod_level_ff <= lvl_field;
      seg_dis_ff   <= (modulation_source_select && am_modulated) ? seg_mask_ff : '0;
    end
  end

  assign trim_pins_group_one = trim_one_ff;
  assign trim_pins_group_two = trim_two_ff;
  assign target_phase        = tphase_ff;
  assign mod_level_use_field = use_field_ff;
  assign mod_level           = mod_level_ff;
  assign segment_disable     = seg_dis_ff;

endmodule : atm_regs

/* File: atm_regs_monitor.sv */
`timescale 1ns/1ps
module atm_regs_monitor #(
  parameter int TRIM_W = 4,
  parameter int LVL_W  = 6,
  parameter int SEG_W  = 8
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Register bus
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic [31:0]       s_axi_rdata,
  // Calibration and driver side
  input wire logic              mod_cal_done,
  input wire logic [LVL_W-1:0]  mod_cal_level,
  input wire logic              am_modulated,
  input wire logic [TRIM_W-1:0] trim_pins_group_one,
  input wire logic [TRIM_W-1:0] trim_pins_group_two,
  input wire logic [7:0]        target_phase,
  input wire logic              mod_level_use_field,
  input wire logic [LVL_W-1:0]  mod_level,
  input wire logic [SEG_W-1:0]  segment_disable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_mod_load;
    mod_cal_done && mod_level_use_field |-> ##2 mod_level == $past(mod_cal_level, 2);
  endproperty

  a_trim_groups_equal: assert property (trim_pins_group_one == trim_pins_group_two)
    else $error("trim groups differ");
  a_reset_outputs: assert property ($rose(aresetn) |-> target_phase == 8'h80 &&
    trim_pins_group_one == '0 && segment_disable == '0 && mod_level_use_field)
    else $error("outputs not at defaults after reset");
  a_seg_idle_zero: assert property (!am_modulated [*3] |-> segment_disable == '0)
    else $error("segments disabled outside modulated state");
  a_seg_field_zero: assert property (mod_level_use_field [*2] |-> segment_disable == '0)
    else $error("segment mask used with field source");
  a_mod_cal_load: assert property (p_mod_load)
    else $error("calibrated level not loaded");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");

  c_mod_load: cover property (mod_cal_done && mod_level_use_field);
  c_seg_mask: cover property (segment_disable != '0);
  c_trim_on: cover property (trim_pins_group_one == 4'hf);
endmodule // atm_regs_monitor

bind atm_regs atm_regs_monitor #(.TRIM_W(TRIM_W), .LVL_W(LVL_W), .SEG_W(SEG_W)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .mod_cal_done(mod_cal_done),
  .mod_cal_level(mod_cal_level), .am_modulated(am_modulated),
  .trim_pins_group_one(trim_pins_group_one), .trim_pins_group_two(trim_pins_group_two),
  .target_phase(target_phase), .mod_level_use_field(mod_level_use_field),
  .mod_level(mod_level), .segment_disable(segment_disable));

/* File: atm_cal_model.sv */
`timescale 1ns/1ps
module atm_cal_model (
  // Clock
  input wire logic  aclk,
  // Calibration engine results
  output logic       ant_cal_done,
  output logic [3:0] ant_cal_result,
  output logic       ant_cal_fail,
  output logic       mod_cal_done,
  output logic [5:0] mod_cal_level
);
  initial begin
    ant_cal_done = 1'b0;
    ant_cal_result = 4'h0;
    ant_cal_fail = 1'b0;
    mod_cal_done = 1'b0;
    mod_cal_level = 6'h00;
  end

  // Result held one cycle, then scrambled
  task ant_cal(input logic [3:0] res, input logic fail);
    @(posedge aclk);
    ant_cal_done <= 1'b1;
    ant_cal_result <= res;
    ant_cal_fail <= fail;
    @(posedge aclk);
    ant_cal_done <= 1'b0;
    ant_cal_result <= ~res;
    ant_cal_fail <= ~fail;
  endtask

  task mod_cal(input logic [5:0] lvl);
    @(posedge aclk);
    mod_cal_done <= 1'b1;
    mod_cal_level <= lvl;
    @(posedge aclk);
    mod_cal_done <= 1'b0;
    mod_cal_level <= ~lvl;
  endtask
endmodule // atm_cal_model

/* File: test_antenna_trim_moddepth_regs.sv */
`timescale 1ns/1ps
module test_antenna_trim_moddepth_regs;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, am_mod, a_done, a_fail, m_done, use_fld;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, trim1, trim2, a_res;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  m_lvl, mod_lvl;
  logic [7:0]  tgt, seg, d;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [11:0] dadr [5] = '{atm_pkg::ADDR_TRIM_SRC_CTRL, atm_pkg::ADDR_CAL_PHASE_TGT,
    atm_pkg::ADDR_CAL_RESULT_DISP, atm_pkg::ADDR_MOD_DEPTH_CTRL, atm_pkg::ADDR_SEGMENT_MASK};
  logic [7:0]  ddef [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};

  initial begin
    aclk = 1'b0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, am_mod} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  always #50 aclk = ~aclk;

  atm_regs dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ant_cal_done(a_done), .ant_cal_result(a_res), .ant_cal_fail(a_fail),
    .mod_cal_done(m_done), .mod_cal_level(m_lvl), .am_modulated(am_mod),
    .trim_pins_group_one(trim1), .trim_pins_group_two(trim2), .target_phase(tgt),
    .mod_level_use_field(use_fld), .mod_level(mod_lvl), .segment_disable(seg));

  atm_cal_model cal (.aclk(aclk), .ant_cal_done(a_done), .ant_cal_result(a_res),
    .ant_cal_fail(a_fail), .mod_cal_done(m_done), .mod_cal_level(m_lvl));

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    int   n;
    tb = 1'b0;
    n = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hf;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!tb) n_mismatch++;
  endtask

  task rd(input logic [11:0] a, output logic [7:0] v, output logic [1:0] rs);
    logic tk, tb;
    int   n;
    tb = 1'b0;
    n = 0;
    @(posedge aclk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    while (!tb && n < 100) begin
      @(negedge aclk);
      tk = arvalid && arready;
      tb = rvalid;
      v = rdata[7:0];
      rs = rresp;
      @(posedge aclk);
      if (tk) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!tb) n_mismatch++;
  endtask

  task rchk(input logic [11:0] a, input logic [7:0] exp);
    rd(a, d, r);
    chk(d, exp);
  endtask

  task settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  task defaults_chk();
    for (int i = 0; i < 5; i++) rchk(dadr[i], ddef[i]);
    chk(tgt, 8'h80);
    chk(use_fld, 1'b1);
    chk(trim1, 4'h0);
  endtask

  task print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    defaults_chk();
    $display("test reset_values done");
    wr(atm_pkg::ADDR_TRIM_SRC_CTRL, 8'hff, r);
    rchk(atm_pkg::ADDR_TRIM_SRC_CTRL, 8'hf8);
    wr(atm_pkg::ADDR_MOD_DEPTH_CTRL, 8'hff, r);
    rchk(atm_pkg::ADDR_MOD_DEPTH_CTRL, 8'hfe);
    wr(atm_pkg::ADDR_CAL_RESULT_DISP, 8'hff, r);
    chk(r, atm_pkg::RESP_OKAY);
    rchk(atm_pkg::ADDR_CAL_RESULT_DISP, 8'h00);
    wr(12'h0fc, 8'h11, r);
    chk(r, atm_pkg::RESP_SLVERR);
    rd(12'h0fc, d, r);
    chk(r, atm_pkg::RESP_SLVERR);
    chk(d, 8'h00);
    wr(atm_pkg::ADDR_MOD_DEPTH_CTRL, 8'h00, r);
    $display("test masks done");
    for (int i = 0; i < 16; i++) begin
      wr(atm_pkg::ADDR_TRIM_SRC_CTRL, {1'b1, i[3:0], 3'h0}, r);
      settle();
      chk(trim1, i[3:0]);
      chk(trim2, i[3:0]);
    end
    $display("test manual_trim done");
    wr(atm_pkg::ADDR_TRIM_SRC_CTRL, 8'h00, r);
    cal.ant_cal(4'h9, 1'b0);
    settle();
    rchk(atm_pkg::ADDR_CAL_RESULT_DISP, 8'h90);
    chk(trim1, 4'h9);
    chk(trim2, 4'h9);
    cal.ant_cal(4'h6, 1'b1);
    settle();
    rchk(atm_pkg::ADDR_CAL_RESULT_DISP, 8'h68);
    wr(atm_pkg::ADDR_TRIM_SRC_CTRL, 8'h98, r);
    cal.ant_cal(4'hc, 1'b0);
    settle();
    chk(trim1, 4'h3);
    rchk(atm_pkg::ADDR_CAL_RESULT_DISP, 8'hc0);
    $display("test cal_result done");
    wr(atm_pkg::ADDR_CAL_PHASE_TGT, 8'h5a, r);
    settle();
    chk(tgt, 8'h5a);
    rchk(atm_pkg::ADDR_CAL_PHASE_TGT, 8'h5a);
    cal.mod_cal(6'h2b);
    settle();
    rchk(atm_pkg::ADDR_MOD_DEPTH_CTRL, 8'h56);
    chk(mod_lvl, 6'h2b);
    wr(atm_pkg::ADDR_SEGMENT_MASK, 8'ha5, r);
    am_mod <= 1'b1;
    settle();
    chk(seg, 8'h00);
    wr(atm_pkg::ADDR_MOD_DEPTH_CTRL, 8'h80, r);
    settle();
    chk(use_fld, 1'b0);
    chk(seg, 8'ha5);
    @(posedge aclk);
    am_mod <= 1'b0;
    settle();
    chk(seg, 8'h00);
    cal.mod_cal(6'h15);
    settle();
    rchk(atm_pkg::ADDR_MOD_DEPTH_CTRL, 8'h80);
    $display("test modulation done");
    wr(atm_pkg::ADDR_CAL_CONTROL, 8'h01, r);
    settle();
    defaults_chk();
    $display("test set_default done");
    print_verdict();
  end
endmodule // test_antenna_trim_moddepth_regs
